//--- verilog/flash_host_pkg.sv
// Package for the flash status and protection-register host controller.
// Assumes a single 40 MHz clock domain and a classic Wishbone slave port.
`default_nettype none
package flash_host_pkg;
  // Register offsets on the Wishbone side (byte addresses).
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_DATA   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  // Command codes written to the command register.
  localparam logic [2:0] OP_READ   = 3'h1;
  localparam logic [2:0] OP_WRITE  = 3'h2;
  localparam logic [2:0] OP_LOCKQ  = 3'h3;
  localparam logic [2:0] OP_OTPRD  = 3'h4;
  localparam logic [2:0] OP_LOCKB  = 3'h5;
  localparam logic [2:0] OP_POLL   = 3'h6;
  localparam logic [2:0] OP_TOGGLE = 3'h7;
  // Flash command addresses and data.
  localparam logic [19:0] UNLOCK_A1 = 20'h0_0555;
  localparam logic [19:0] UNLOCK_A2 = 20'h0_0AAA;
  localparam logic [19:0] LOCK_ADDR = 20'h0_0080;
  localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_D2 = 16'h0055;
  localparam logic [15:0] IDENT_ENTER_D = 16'h0090;
  localparam logic [15:0] IDENT_LEAVE_D = 16'h00F0;
  localparam logic [15:0] PROT_PROG_D   = 16'h00C0;
  localparam logic [15:0] LOCK_DATA     = 16'h0000;
  // Status bit positions on the data lines.
  localparam int LOCK_FLAG_BIT   = 1;
  localparam int SUPPLY_LOW_BIT  = 3;
  localparam int TIMEOUT_BIT     = 5;
  localparam int TOGGLE_BIT      = 6;
  localparam int POLARITY_BIT    = 7;
  // Bus cycle timing: 25 ns clock, 70 ns access, 50 ns strobe pulse.
  localparam int CLK_NS    = 25;
  localparam int ACCESS_NS = 70;
  localparam int PULSE_NS  = 50;
  localparam logic [2:0] ACCESS_CYC = 3'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] PULSE_CYC  = 3'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  // Status register bits.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_VLOW = 3;
  localparam int ST_RDYB = 4;
  // One flash bus request.
  typedef struct packed {
    logic        write;
    logic [19:0] addr;
    logic [15:0] data;
  } flash_req_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_SETUP = 4'b0001,
    S_PULSE = 4'b0010,
    S_GAP   = 4'b0011,
    S_NEXT  = 4'b0100,
    S_DONE  = 4'b0101
  } fsm_t;
endpackage : flash_host_pkg
`default_nettype wire

//--- verilog/flash_host_ctrl.sv
// Host controller that drives the flash through its parallel pins.
// Software orders sequences over classic Wishbone; pins are synchronous to clk_i.
// Notes on behaviour
// - lock cycle four drives lock bit low.
// - lock query: ident entry, read 80H bit.
// - protection read: ident entry, then plain read.
// - ident leave command follows every ident access.
// - polling rereads polarity bit after timeout bit.
// - toggle routine rereads toggle after timeout bit.
// - status polls use the programmed address.
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Flash pins.
  output logic [19:0]      fl_addr_o,
  output logic [15:0]      fl_dq_o,
  output logic             fl_dq_oe_n_o,
  input  wire logic [15:0] fl_dq_i,
  output logic             fl_ce_n_o,
  output logic             fl_oe_n_o,
  output logic             fl_we_n_o,
  input  wire logic        fl_ready_i
);
  fsm_t        state;
  flash_req_t  seq [0:4];
  logic [2:0]  seq_len;
  logic [2:0]  idx;
  logic [2:0]  cnt;
  logic [2:0]  op;
  logic [19:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] rd_data;
  logic [15:0] prev_rd;
  logic        have_prev;
  logic        recheck;
  logic        busy, done, fail, vlow;

  // Builds one write cycle; used for the unlock prefix and the command words.
  function automatic flash_req_t wr(input logic [19:0] a, input logic [15:0] d);
    wr = '{write: 1'b1, addr: a, data: d};
  endfunction : wr

  function automatic flash_req_t rd(input logic [19:0] a);
    rd = '{write: 1'b0, addr: a, data: 16'h0000};
  endfunction : rd

  // Bus decode.
  wire bus_req  = cyc_i & stb_i & ~ack_o;
  wire cmd_wr   = bus_req & we_i & sel_i[0] & (adr_i == REG_CMD) & ~busy;
  wire addr_wr  = bus_req & we_i & (adr_i == REG_ADDR);
  wire data_wr  = bus_req & we_i & (adr_i == REG_DATA);
  wire [2:0] new_op = dat_i[2:0];
  wire flash_req_t cur = seq[idx];
  wire last_step = (idx == seq_len - 3'd1);
  // Polling verdicts for the two status methods.
  wire tmo_seen  = rd_data[TIMEOUT_BIT] | rd_data[SUPPLY_LOW_BIT];
  wire pol_match = rd_data[POLARITY_BIT] == data_reg[POLARITY_BIT];
  wire tog_still = have_prev & (rd_data[TOGGLE_BIT] == prev_rd[TOGGLE_BIT]);
  wire poll_ok   = (op == OP_POLL) ? pol_match : tog_still;

  // Wishbone register reads; the command offset and unmapped offsets answer the current op.
  logic [31:0] rd_mux;
  assign rd_mux = (adr_i == REG_ADDR)   ? {12'h000, addr_reg} :
                  (adr_i == REG_DATA)   ? {16'h0000, rd_data} :
                  (adr_i == REG_STATUS) ? {27'h000_0000, fl_ready_i, vlow, fail, done, busy} :
                  {29'h0000_0000, op};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= 20'h0_0000;
      data_reg <= 16'h0000;
    end else begin
      if (addr_wr) addr_reg <= dat_i[19:0];
      if (data_wr) data_reg <= dat_i[15:0];
    end
  end

  // Sequence builder: loads the bus cycles for the ordered operation.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op      <= 3'h0;
      seq_len <= 3'd0;
      for (int i = 0; i < 5; i++) seq[i] <= '0;
    end else if (cmd_wr) begin
      op <= new_op;
      seq[0] <= wr(UNLOCK_A1, UNLOCK_D1);
      seq[1] <= wr(UNLOCK_A2, UNLOCK_D2);
      seq[2] <= wr(UNLOCK_A1, IDENT_ENTER_D);
      seq[4] <= wr(UNLOCK_A1, IDENT_LEAVE_D);
      case (new_op)
        OP_READ, OP_POLL, OP_TOGGLE: begin
          seq[0] <= rd(addr_reg);
          seq_len <= 3'd1;
        end
        OP_WRITE: begin
          seq[0] <= wr(addr_reg, data_reg);
          seq_len <= 3'd1;
        end
        OP_LOCKQ: begin
          seq[3] <= rd(LOCK_ADDR);
          seq_len <= 3'd4;
        end
        OP_OTPRD: begin
          seq[3] <= rd(addr_reg);
          seq_len <= 3'd4;
        end
        OP_LOCKB: begin
          seq[2] <= wr(UNLOCK_A1, PROT_PROG_D);
          seq[3] <= wr(LOCK_ADDR, LOCK_DATA);
          seq_len <= 3'd4;
        end
        default: seq_len <= 3'd0;
      endcase
      // Ident sequences run the leave command as a fifth cycle.
      if (new_op == OP_LOCKQ || new_op == OP_OTPRD) seq_len <= 3'd5;
    end
  end

  // Bus cycle engine; polling ops repeat the read until the status settles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      idx       <= 3'd0;
      cnt       <= 3'd0;
      busy      <= 1'b0;
      done      <= 1'b0;
      fail      <= 1'b0;
      vlow      <= 1'b0;
      rd_data   <= 16'h0000;
      prev_rd   <= 16'h0000;
      have_prev <= 1'b0;
      recheck   <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (cmd_wr && new_op != 3'h0) begin
            state <= S_SETUP;
            idx <= 3'd0;
            busy <= 1'b1;
            done <= 1'b0;
            fail <= 1'b0;
            vlow <= 1'b0;
            have_prev <= 1'b0;
            recheck <= 1'b0;
          end
        end
        S_SETUP: begin
          state <= S_PULSE;
          cnt <= cur.write ? PULSE_CYC : ACCESS_CYC;
        end
        S_PULSE: begin
          if (cnt == 3'd1) begin
            state <= S_GAP;
            if (!cur.write) rd_data <= fl_dq_i;
          end else cnt <= cnt - 3'd1;
        end
        S_GAP: state <= S_NEXT;
        S_NEXT: begin
          if ((op == OP_POLL || op == OP_TOGGLE) && !poll_ok) begin
            prev_rd <= rd_data;
            have_prev <= 1'b1;
            if (recheck) begin
              // Second look after the timeout bit still disagrees: fail.
              fail <= 1'b1;
              vlow <= rd_data[SUPPLY_LOW_BIT];
              state <= S_DONE;
            end else begin
              recheck <= tmo_seen;
              state <= S_SETUP;
            end
          end else if (last_step || op == OP_POLL || op == OP_TOGGLE) begin
            state <= S_DONE;
          end else begin
            idx <= idx + 3'd1;
            state <= S_SETUP;
          end
        end
        S_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Pin drive from the current step; dq output enable is low while driving.
  wire active = (state == S_SETUP) || (state == S_PULSE) || (state == S_GAP);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_addr_o    <= 20'h0_0000;
      fl_dq_o      <= 16'h0000;
      fl_dq_oe_n_o <= 1'b1;
      fl_ce_n_o    <= 1'b1;
      fl_oe_n_o    <= 1'b1;
      fl_we_n_o    <= 1'b1;
    end else begin
      fl_addr_o    <= cur.addr;
      fl_dq_o      <= cur.data;
      fl_dq_oe_n_o <= ~(active & cur.write);
      fl_ce_n_o    <= ~active;
      // Output enable stays high during writes so the device takes them.
      fl_oe_n_o    <= ~((state == S_PULSE) & ~cur.write);
      fl_we_n_o    <= ~((state == S_PULSE) & cur.write);
    end
  end

  // Never strobe write and output enable together.
  strobe_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(!fl_we_n_o && !fl_oe_n_o)) else $error("write and read strobes overlap");
  // A write strobe always has chip enable and driven data.
  write_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fl_we_n_o |-> (!fl_ce_n_o && !fl_dq_oe_n_o)) else $error("write without drive");
  // Lock query reads address 80H after the entry command.
  sequence ident_entry_s;
    !fl_we_n_o && fl_dq_o == IDENT_ENTER_D;
  endsequence
  lock_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (op == OP_LOCKQ && idx == 3'd3 && !fl_oe_n_o) |-> fl_addr_o == LOCK_ADDR)
    else $error("lock query at wrong address");
  // Only ident sequences count: a plain data write may carry the same word.
  sequence ident_op_s;
    (op == OP_LOCKQ || op == OP_OTPRD) && ident_entry_s;
  endsequence
  sequence ident_leave_s;
    !fl_we_n_o && fl_dq_o == IDENT_LEAVE_D;
  endsequence
  ident_leave_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ident_op_s |-> ##[1:40] ident_leave_s)
    else $error("ident mode not left");
  // The lock cycle targets the lock word and keeps the lock bit low.
  lock_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (op == OP_LOCKB && idx == 3'd3 && !fl_we_n_o) |->
    (fl_addr_o == LOCK_ADDR && !fl_dq_o[LOCK_FLAG_BIT]))
    else $error("lock cycle data wrong");
  // Status polls read the programmed word's address.
  poll_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((op == OP_POLL || op == OP_TOGGLE) && !fl_oe_n_o) |-> fl_addr_o == addr_reg)
    else $error("poll at wrong address");
  // The host never drives the data lines while the device is read.
  read_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fl_oe_n_o |-> fl_dq_oe_n_o)
    else $error("host drives during read");
endmodule : flash_host_ctrl
`default_nettype wire

//--- dv/flash_dev_model.sv
// Behavioural flash device seen from its parallel pins.
// Assumes the bench resolves the shared data bus from the host drive enable alone.
`default_nettype none
module flash_dev_model #(
  parameter int BUSY_NS = 2000
) (
  // Flash pins.
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  output logic      [15:0] dq_o,
  output logic             ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem[int];
  logic [15:0] last = 16'h0000;
  logic [15:0] pd = 16'h0000;
  logic        busy = 1'b0;
  logic        tog = 1'b0;
  logic        ident = 1'b0;
  logic        lockb = 1'b0;
  logic        prog = 1'b0;
  logic        prot = 1'b0;
  int          step = 0;
  // Supply is always in range here, so no inhibit window ever blocks a write.
  // Commands latch on the rising write strobe; writes during a busy cycle are dropped.
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && !busy) begin
      if (prot) begin
        lockb = lockb | (addr_i[11:0] == 12'h080 && !dq_i[1]);
        prot = 0;
      end else if (prog) begin
        mem[addr_i] = dq_i;
        pd = dq_i;
        prog = 0;
        busy = 1;
        busy <= #(BUSY_NS) 1'b0;
      end else if (dq_i[7:0] == 8'hF0) begin
        ident = 0;
        step = 0;
      end else if (step == 0 && dq_i[7:0] == 8'hAA && addr_i[11:0] == 12'h555) step = 1;
      else if (step == 1 && dq_i[7:0] == 8'h55) step = 2;
      else if (step == 2) begin
        ident = ident | dq_i[7:0] == 8'h90;
        prog = dq_i[7:0] == 8'hA0;
        prot = dq_i[7:0] == 8'hC0;
        step = 0;
      end else step = 0;
    end
  end
  // Each output-enable fall while busy and chip-enabled flips the toggle bit.
  always @(negedge oe_n_i) if (busy && !ce_n_i) tog = ~tog;
  // A released bus shows the inverse of the last word, never a stale copy.
  always @(addr_i, ce_n_i, oe_n_i, busy, tog, ident, lockb) begin
    if (ce_n_i || oe_n_i) dq_o = ~last;
    else begin
      if (busy) dq_o = {8'h00, ~pd[7], tog, 6'b000100};
      else if (ident && addr_i[11:0] == 12'h080) dq_o = {14'h0000, !lockb, 1'b0};
      else if (ident) dq_o = {8'hA5, addr_i[7:0]};
      else dq_o = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
      last = dq_o;
    end
  end
  // Ready is driven high whenever the device is not busy.
  assign ready_o = !busy;
endmodule : flash_dev_model
`default_nettype wire

//--- dv/test_flash_host_ctrl.sv
// Self-checking bench: Wishbone orders to the host controller, device model behind it.
// Assumes the controller answers every Wishbone request within a few cycles.
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; $display("Error %0t got %h exp %h", $time, a, b); end end
module test_flash_host_ctrl import flash_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we, ack, fl_ready, dq_oe_n, ce_n, oe_n, we_n;
  logic [3:0]  adr;
  logic [31:0] dat, dat_o, r, st;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq, dev_dq, dq_bus;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          exp_mem[int];
  // The host wins the shared bus whenever it enables its drivers.
  assign dq_bus = dq_oe_n ? dev_dq : fl_dq;
  flash_host_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .fl_addr_o(fl_addr), .fl_dq_o(fl_dq),
    .fl_dq_oe_n_o(dq_oe_n), .fl_dq_i(dq_bus), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n),
    .fl_ready_i(fl_ready));
  flash_dev_model dev (.addr_i(fl_addr), .dq_i(dq_bus), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .dq_o(dev_dq), .ready_o(fl_ready));
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin num_errors++; conclude(); end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Loads address and data, starts a command, waits for idle, reads the result.
  task automatic op(input logic [2:0] c, input logic [19:0] a, input logic [15:0] d);
    int n;
    wb(1'b1, REG_ADDR, 32'(a), r);
    wb(1'b1, REG_DATA, 32'(d), r);
    wb(1'b1, REG_CMD, 32'(c), r);
    n = 0;
    do begin wb(1'b0, REG_STATUS, 32'h0000_0000, r); n++; end while (r[ST_BUSY] !== 1'b0 && n < 2000);
    if (r[ST_BUSY] !== 1'b0) begin num_errors++; conclude(); end
    st = r;
    wb(1'b0, REG_DATA, 32'h0000_0000, r);
  endtask : op
  // Free-running 40 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Main sequence; the bench keeps its own image of programmed words.
  initial begin
    logic [19:0] a;
    logic [15:0] d;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    dat = 32'h0000_0000;
    void'($urandom(101));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 4'h2, 32'h0000_0000, r);
    op(OP_LOCKQ, 20'h0_0000, 16'h0000);
    `CHK(r[1], 1'b1)
    `CHK(dev.ident, 1'b0)
    op(OP_OTPRD, 20'h0_0085, 16'h0000);
    `CHK(r[15:0], 16'hA585)
    `CHK(dev.ident, 1'b0)
    op(OP_LOCKB, 20'h0_0000, 16'h0000);
    op(OP_LOCKQ, 20'h0_0000, 16'h0000);
    `CHK(r[1], 1'b0)
    for (int i = 0; i < 4; i++) begin
      a = {4'h1, 16'($urandom)};
      d = 16'($urandom);
      exp_mem[int'(a)] = d;
      op(OP_WRITE, UNLOCK_A1, UNLOCK_D1);
      op(OP_WRITE, UNLOCK_A2, UNLOCK_D2);
      op(OP_WRITE, UNLOCK_A1, 16'h00A0);
      op(OP_WRITE, a, d);
      wb(1'b0, REG_STATUS, 32'h0000_0000, r);
      `CHK(r[ST_RDYB], 1'b0)
      op(i[0] ? OP_TOGGLE : OP_POLL, a, d);
      `CHK(st[ST_FAIL:ST_DONE], 2'b01)
      `CHK(st[ST_RDYB], 1'b1)
      op(OP_READ, a, 16'h0000);
      `CHK(r[15:0], 16'(exp_mem[int'(a)]))
    end
    conclude();
  end
endmodule : test_flash_host_ctrl
`default_nettype wire
